// [design/lmfc_sync_regs.svh]
// register offsets, field positions, reset values and codes of the lmfc sync control block
// assumes an 12-bit byte register address from the serial control port
`ifndef LMFC_SYNC_REGS_SVH
`define LMFC_SYNC_REGS_SVH

`define ADDR_CHECK_FLAGS 12'h0030
`define ADDR_ERR_WINDOW 12'h0034
`define ADDR_PREV_ERR_LOW 12'h0038
`define ADDR_PREV_ERR_HIGH 12'h0039
`define ADDR_SYNC_CONTROL 12'h003A
`define ADDR_SYNC_STATUS 12'h003B
`define ADDR_PRESENT_ERR 12'h003C

`define CTRL_ALIGN_ON 7
`define CTRL_ARM 6
`define CTRL_CLR_STICKY 5
`define CTRL_CLR_PREV 4
`define CTRL_MODE_MSB 3
`define HIGH_BELOW_BIT 7
`define HIGH_ABOVE_BIT 6
`define CHECK_SUBCLASS_BIT 1
`define CHECK_INTERP_BIT 0
`define STAT_BUSY_BIT 7
`define STAT_LOCK_BIT 3
`define STAT_ROTATE_BIT 2
`define STAT_OUTSIDE_BIT 1
`define STAT_TRIP_BIT 0

`define RESET_BYTE 8'h00
`define RESET_NIBBLE 4'h0
`define RESET_WINDOW 2'h0

`define MODE_ONE_SHOT 4'h1
`define MODE_CONTINUOUS 4'h2
`define MODE_MONITOR 4'h8
`define MODE_ONE_SHOT_MON 4'h9

`define SUBCLASS_MAX 3'h1
`define INTERP_X1 4'h1
`define INTERP_X2 4'h2
`define INTERP_X4 4'h4
`define INTERP_X8 4'h8

`define LMFC_STEP 4'h1
`define LMFC_AFTER_ADJUST 4'h1

`endif

// [design/lmfc_sync_pkg.sv]
// types shared by the lmfc sync control block
// assumes nothing of its surroundings
package lmfc_sync_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_TRACK = 2'b10
  } align_state_t;
endpackage : lmfc_sync_pkg

// [design/lmfc_phase_tracker.sv]
// local multiframe clock phase counter
// assumes adjust_in is a one-cycle pulse in the clk_in domain
`timescale 1ns/1ps
`include "lmfc_sync_regs.svh"
module lmfc_phase_tracker (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic adjust_in,
  output logic [3:0] phase_out
);
  // the count wraps at 16, so read as signed it is the phase error itself
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      phase_out <= `RESET_NIBBLE;
    end else if (adjust_in) begin
      phase_out <= `LMFC_AFTER_ADJUST;
    end else begin
      phase_out <= phase_out + `LMFC_STEP;
    end
  end
endmodule : lmfc_phase_tracker

// [design/lmfc_sync_control.sv]
// lmfc to sysref alignment control, error capture and configuration checks
// assumes a register port from the serial control port on clk_in (dac clock domain)
`timescale 1ns/1ps
`include "lmfc_sync_regs.svh"
module lmfc_sync_control
  import lmfc_sync_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic reg_write_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic sysref_in,
  input wire logic [2:0] subclass_in,
  input wire logic [3:0] interp_factor_in,
  output logic align_busy_out,
  output logic align_locked_out
);
  // ----------------------------------------
  // registers and state
  // ----------------------------------------
  logic [1:0] phase_tolerance;
  logic [7:0] sync_control;
  logic [7:0] control_prev;
  logic [3:0] prev_phase_error;
  logic prev_below_window;
  logic prev_above_window;
  logic [3:0] present_phase_error;
  logic outside_window;
  logic rotated_sticky;
  logic tripped_sticky;
  logic [7:0] link_config_check_flags;
  logic sysref_meta;
  logic sysref_sync;
  logic sysref_prev;
  align_state_t state;
  align_state_t next_state;
  logic [3:0] lmfc_phase;

  // ----------------------------------------
  // decoding
  // ----------------------------------------
  function automatic logic [1:0] window_side(input logic [3:0] err, input logic [1:0] win);
    logic signed [4:0] e;
    logic signed [4:0] w;
    e = {err[3], err};
    w = {3'b000, win};
    window_side = {(e < -w), (e > w)};
  endfunction : window_side

  wire align_logic_on = sync_control[`CTRL_ALIGN_ON];
  wire [3:0] align_mode_select = sync_control[`CTRL_MODE_MSB:0];
  wire align_arm_strobe = sync_control[`CTRL_ARM] & ~control_prev[`CTRL_ARM];
  wire sticky_clear_strobe = sync_control[`CTRL_CLR_STICKY] & ~control_prev[`CTRL_CLR_STICKY];
  wire prev_error_clear_strobe = sync_control[`CTRL_CLR_PREV] & ~control_prev[`CTRL_CLR_PREV];
  wire mode_one_shot = (align_mode_select == `MODE_ONE_SHOT) |
                       (align_mode_select == `MODE_ONE_SHOT_MON);
  wire mode_continuous = (align_mode_select == `MODE_CONTINUOUS);
  wire mode_monitor = (align_mode_select == `MODE_MONITOR) |
                      (align_mode_select == `MODE_ONE_SHOT_MON);
  wire mode_monitor_only = (align_mode_select == `MODE_MONITOR);
  wire sysref_pulse = sysref_sync & ~sysref_prev;
  wire [1:0] side = window_side(lmfc_phase, phase_tolerance);
  wire measure = sysref_pulse & align_logic_on &
                 (mode_monitor | mode_continuous | (state == ST_ARMED));
  // only a phase outside the window adjusts
  // no adjust while disabled
  // a mode change leaves track one cycle late, so track adjusts only while still continuous
  wire adjust = measure & (side != 2'b00) & ~mode_monitor_only &
                ((state == ST_ARMED) | ((state == ST_TRACK) & mode_continuous));
  wire bad_subclass_flag = (subclass_in > `SUBCLASS_MAX);
  wire bad_interp_flag = ~((interp_factor_in == `INTERP_X1) | (interp_factor_in == `INTERP_X2) |
                           (interp_factor_in == `INTERP_X4) | (interp_factor_in == `INTERP_X8));
  wire wr_window = reg_write_in & (reg_addr_in == `ADDR_ERR_WINDOW);
  wire wr_control = reg_write_in & (reg_addr_in == `ADDR_SYNC_CONTROL);

  lmfc_phase_tracker u_tracker (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .adjust_in(adjust),
    .phase_out(lmfc_phase)
  );

  // ----------------------------------------
  // sysref synchroniser and edge
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sysref_meta <= 1'b0;
      sysref_sync <= 1'b0;
      sysref_prev <= 1'b0;
    end else begin
      sysref_meta <= sysref_in;
      sysref_sync <= sysref_meta;
      sysref_prev <= sysref_sync;
    end
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  // everything resets to zero
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      phase_tolerance <= `RESET_WINDOW;
      sync_control <= `RESET_BYTE;
      control_prev <= `RESET_BYTE;
      link_config_check_flags <= `RESET_BYTE;
    end else begin
      if (wr_window) begin
        phase_tolerance <= reg_wdata_in[1:0];
      end
      if (wr_control) begin
        sync_control <= reg_wdata_in;
      end
      control_prev <= sync_control;
      link_config_check_flags <= {6'b000000, bad_subclass_flag, bad_interp_flag};
    end
  end

  // ----------------------------------------
  // alignment state machine
  // ----------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (align_logic_on && mode_continuous) begin
          next_state = ST_TRACK;
        end else if (align_logic_on && mode_one_shot && align_arm_strobe) begin
          next_state = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (!align_logic_on || sysref_pulse) begin
          next_state = ST_IDLE;
        end
      end
      ST_TRACK: begin
        if (!align_logic_on || !mode_continuous) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // error capture and status
  // ----------------------------------------
  // a set in the same cycle as a clear strobe wins, so no event is lost
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prev_phase_error <= `RESET_NIBBLE;
      prev_below_window <= 1'b0;
      prev_above_window <= 1'b0;
    end else if (adjust) begin
      prev_phase_error <= lmfc_phase;
      prev_below_window <= side[1];
      prev_above_window <= side[0];
    end else if (prev_error_clear_strobe) begin
      prev_phase_error <= `RESET_NIBBLE;
      prev_below_window <= 1'b0;
      prev_above_window <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      present_phase_error <= `RESET_NIBBLE;
      outside_window <= 1'b0;
      align_locked_out <= 1'b0;
    end else if (!align_logic_on) begin
      align_locked_out <= 1'b0;
    end else if (measure) begin
      present_phase_error <= adjust ? `RESET_NIBBLE : lmfc_phase;
      outside_window <= (side != 2'b00);
      align_locked_out <= adjust | (side == 2'b00);
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rotated_sticky <= 1'b0;
      tripped_sticky <= 1'b0;
    end else begin
      if (adjust) begin
        rotated_sticky <= 1'b1;
      end else if (sticky_clear_strobe) begin
        rotated_sticky <= 1'b0;
      end
      if (sysref_pulse && state == ST_ARMED) begin
        tripped_sticky <= 1'b1;
      end else if (sticky_clear_strobe) begin
        tripped_sticky <= 1'b0;
      end
    end
  end

  assign align_busy_out = (state != ST_IDLE);

  // ----------------------------------------
  // read port, one cycle latency
  // ----------------------------------------
  logic [7:0] read_value;
  always_comb begin
    read_value = `RESET_BYTE;
    unique case (reg_addr_in)
      `ADDR_CHECK_FLAGS: read_value = link_config_check_flags;
      `ADDR_ERR_WINDOW: read_value = {6'b000000, phase_tolerance};
      `ADDR_PREV_ERR_LOW: read_value = {4'h0, prev_phase_error};
      `ADDR_PREV_ERR_HIGH: read_value = {prev_below_window, prev_above_window, 6'b000000};
      `ADDR_SYNC_CONTROL: read_value = sync_control;
      `ADDR_SYNC_STATUS: read_value = {align_busy_out, 3'b000, align_locked_out,
                                       rotated_sticky, outside_window, tripped_sticky};
      `ADDR_PRESENT_ERR: read_value = {4'h0, present_phase_error};
      default: read_value = `RESET_BYTE;
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= `RESET_BYTE;
    end else begin
      reg_rdata_out <= read_value;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_subclass;
    @(posedge clk_in) disable iff (!reset_n_in)
      ##1 link_config_check_flags[`CHECK_SUBCLASS_BIT] == $past(subclass_in > `SUBCLASS_MAX);
  endproperty
  a_subclass: assert property (p_subclass) else $error("subclass flag wrong");

  property p_interp;
    @(posedge clk_in) disable iff (!reset_n_in)
      (interp_factor_in == 4'h3) |=> link_config_check_flags[0];
  endproperty
  a_interp: assert property (p_interp) else $error("interp flag missed");

  property p_in_window;
    @(posedge clk_in) disable iff (!reset_n_in)
      (sysref_pulse && side == 2'b00) |=> lmfc_phase == $past(lmfc_phase) + `LMFC_STEP;
  endproperty
  a_in_window: assert property (p_in_window) else $error("adjust inside window");

  property p_capture;
    @(posedge clk_in) disable iff (!reset_n_in)
      adjust |=> (prev_phase_error == $past(lmfc_phase)) && (lmfc_phase == 4'h1);
  endproperty
  a_capture: assert property (p_capture) else $error("last error not captured");

  property p_below;
    @(posedge clk_in) disable iff (!reset_n_in)
      (adjust && side[1]) |=> prev_below_window && !prev_above_window;
  endproperty
  a_below: assert property (p_below) else $error("below flag missed");

  property p_above;
    @(posedge clk_in) disable iff (!reset_n_in)
      (adjust && side[0]) |=> prev_above_window && !prev_below_window;
  endproperty
  a_above: assert property (p_above) else $error("above flag missed");

  property p_disable;
    @(posedge clk_in) disable iff (!reset_n_in)
      !align_logic_on |=> (state == ST_IDLE) && !align_locked_out;
  endproperty
  a_disable: assert property (p_disable) else $error("logic ran while disabled");

  property p_arm;
    @(posedge clk_in) disable iff (!reset_n_in)
      (state == ST_ARMED && sysref_pulse && align_logic_on) |=> state == ST_IDLE && tripped_sticky;
  endproperty
  a_arm: assert property (p_arm) else $error("one-shot did not complete");

  property p_clr_sticky;
    @(posedge clk_in) disable iff (!reset_n_in)
      (sticky_clear_strobe && !adjust && !sysref_pulse) |=> !rotated_sticky && !tripped_sticky;
  endproperty
  a_clr_sticky: assert property (p_clr_sticky) else $error("sticky not cleared");

  property p_clr_prev;
    @(posedge clk_in) disable iff (!reset_n_in)
      (prev_error_clear_strobe && !adjust) |=> prev_phase_error == 4'h0 && !prev_below_window;
  endproperty
  a_clr_prev: assert property (p_clr_prev) else $error("last error not cleared");

  property p_present_zero;
    @(posedge clk_in) disable iff (!reset_n_in)
      adjust |=> present_phase_error == 4'h0 && rotated_sticky && align_locked_out;
  endproperty
  a_present_zero: assert property (p_present_zero) else $error("present error not zeroed");

  property p_monitor;
    @(posedge clk_in) disable iff (!reset_n_in)
      (align_mode_select == `MODE_MONITOR || !align_logic_on) |-> !adjust;
  endproperty
  a_monitor: assert property (p_monitor) else $error("adjust in monitor or disabled");

  property p_continuous;
    @(posedge clk_in) disable iff (!reset_n_in)
      (state == ST_IDLE && align_logic_on && mode_continuous) |=> align_busy_out;
  endproperty
  a_continuous: assert property (p_continuous) else $error("continuous mode not busy");
endmodule : lmfc_sync_control

// [tb/sysref_source.sv]
// sysref source model facing the alignment block
// assumes fire_in is a one-cycle request on clk_in; the pulse lasts two cycles
`timescale 1ns/1ps
module sysref_source (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic fire_in,
  output logic sysref_out
);
  logic [1:0] left;
  // ----------------------------------------
  // pulse shaping
  // ----------------------------------------
  // two cycles high so the receiver's sync flops cannot miss it
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      left <= 2'h0;
    end else if (fire_in) begin
      left <= 2'h2;
    end else if (left != 2'h0) begin
      left <= left - 2'h1;
    end
  end
  assign sysref_out = (left != 2'h0);
endmodule : sysref_source

// [tb/test_lmfc_sync_control.sv]
// self-checking bench for the lmfc sync control block
// assumes the register port and the sysref source model, one 25 MHz clock
`timescale 1ns/1ps
module test_lmfc_sync_control;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [11:0] reg_addr_in = 12'h000;
  logic reg_write_in = 1'b0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic [7:0] reg_rdata_out;
  logic sysref_in;
  logic fire = 1'b0;
  logic [2:0] subclass_in = 3'h0;
  logic [3:0] interp_factor_in = 4'h1;
  logic align_busy_out;
  logic align_locked_out;
  int failures = 0;
  int compares = 0;
  int cyc = 0;
  int last = 0;
  // the lmfc count seen at the sysref pulse runs one behind cyc after reset
  int adj = 1;

  lmfc_sync_control dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .reg_addr_in(reg_addr_in), .reg_write_in(reg_write_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .sysref_in(sysref_in), .subclass_in(subclass_in),
    .interp_factor_in(interp_factor_in), .align_busy_out(align_busy_out),
    .align_locked_out(align_locked_out));
  sysref_source src_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .fire_in(fire),
    .sysref_out(sysref_in));

  initial begin
    forever #20 clk_in = ~clk_in;
  end
  always @(posedge clk_in) cyc <= cyc + 1;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask : check
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge clk_in);
    reg_write_in <= 1'b0;
  endtask : wr
  task rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge clk_in);
    reg_addr_in <= a;
    @(posedge clk_in);
    #1 check(reg_rdata_out & m, exp);
  endtask : rd
  // fires when the lmfc count since the last adjust equals e; gaps stay above 16
  task pulse_err(input int e);
    @(posedge clk_in);
    while ((cyc - last) < 17 || ((cyc - adj) & 15) != e) @(posedge clk_in);
    last = cyc;
    fire <= 1'b1;
    @(posedge clk_in);
    fire <= 1'b0;
    repeat (5) @(posedge clk_in);
  endtask : pulse_err
  task conclude;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (20000) @(posedge clk_in);
    failures++;
    conclude();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd(12'h034, 8'hff, 8'h00);
    rd(12'h039, 8'hff, 8'h00);
    rd(12'h03a, 8'hff, 8'h00);
    check({7'h0, align_busy_out}, 8'h00);
    wr(12'h034, 8'hff);
    rd(12'h034, 8'hff, 8'h03);
    wr(12'h034, 8'h00);
    for (int s = 0; s < 8; s++) begin
      @(posedge clk_in) subclass_in <= 3'(s);
      rd(12'h030, 8'h02, (s > 1) ? 8'h02 : 8'h00);
    end
    @(posedge clk_in) subclass_in <= 3'h1;
    for (int f = 0; f < 16; f++) begin
      @(posedge clk_in) interp_factor_in <= 4'(f);
      rd(12'h030, 8'h01, (f == 1 || f == 2 || f == 4 || f == 8) ? 8'h00 : 8'h01);
    end
    @(posedge clk_in) interp_factor_in <= 4'h4;
    // continuous mode, window zero then two
    wr(12'h03a, 8'h82);
    pulse_err(15);
    adj = last;
    rd(12'h038, 8'hff, 8'h0f);
    rd(12'h039, 8'hff, 8'h80);
    pulse_err(5);
    adj = last;
    rd(12'h038, 8'hff, 8'h05);
    rd(12'h039, 8'hff, 8'h40);
    rd(12'h03c, 8'h0f, 8'h00);
    wr(12'h034, 8'h02);
    pulse_err(13);
    adj = last;
    rd(12'h038, 8'hff, 8'h0d);
    rd(12'h039, 8'hff, 8'h80);
    pulse_err(2);
    rd(12'h038, 8'hff, 8'h0d);
    rd(12'h03c, 8'h0f, 8'h02);
    check({7'h0, align_locked_out}, 8'h01);
    pulse_err(3);
    adj = last;
    rd(12'h038, 8'hff, 8'h03);
    rd(12'h039, 8'hff, 8'h40);
    // one-shot: arm, trip once, then ignore sysref
    wr(12'h03a, 8'h81);
    wr(12'h03a, 8'hc1);
    repeat (3) @(posedge clk_in);
    #1 check({7'h0, align_busy_out}, 8'h01);
    pulse_err(6);
    adj = last;
    #1 check({7'h0, align_busy_out}, 8'h00);
    rd(12'h038, 8'hff, 8'h06);
    rd(12'h03b, 8'hff, 8'h0f);
    pulse_err(4);
    rd(12'h038, 8'hff, 8'h06);
    wr(12'h03a, 8'ha1);
    rd(12'h03b, 8'hff, 8'h0a);
    rd(12'h038, 8'hff, 8'h06);
    wr(12'h03a, 8'h91);
    rd(12'h038, 8'hff, 8'h00);
    rd(12'h039, 8'hff, 8'h00);
    // monitor only
    wr(12'h03a, 8'h88);
    pulse_err(7);
    rd(12'h038, 8'hff, 8'h00);
    rd(12'h03c, 8'h0f, 8'h07);
    // one-shot then monitor
    wr(12'h03a, 8'h89);
    wr(12'h03a, 8'hc9);
    pulse_err(5);
    adj = last;
    rd(12'h038, 8'hff, 8'h05);
    pulse_err(6);
    rd(12'h038, 8'hff, 8'h05);
    // disabled logic in continuous mode
    wr(12'h03a, 8'h02);
    pulse_err(7);
    rd(12'h038, 8'hff, 8'h05);
    check({7'h0, align_locked_out}, 8'h00);
    rd(12'h03a, 8'hff, 8'h02);
    conclude();
  end
endmodule : test_lmfc_sync_control
